// ---- hw/gsc_pkg.sv ----
// Shared constants, types and the checksum function of the gas sensor command port.
package gsc_pkg;

    localparam logic [6:0] GSC_ADDR = 7'h59;
    localparam logic [7:0] GSC_GC_HDR = 8'h00;
    localparam logic [7:0] GSC_GC_RESET = 8'h06;
    localparam logic [15:0] GSC_CMD_MEASURE = 16'h260f;
    localparam logic [15:0] GSC_CMD_SELF_TEST = 16'h280e;
    localparam logic [15:0] GSC_CMD_HEATER_OFF = 16'h3615;
    localparam logic [15:0] GSC_CMD_READ_ID = 16'h3682;

    localparam logic [7:0] GSC_CRC_POLY = 8'h31;
    localparam logic [7:0] GSC_CRC_INIT = 8'hff;
    localparam logic [7:0] GSC_CRC_XOR = 8'h00;
    localparam logic [15:0] GSC_RH_DEFAULT = 16'h8000;
    localparam logic [15:0] GSC_TEMP_DEFAULT = 16'h6666;
    localparam logic [7:0] GSC_ST_PASS = 8'hd4;
    localparam logic [7:0] GSC_ST_FAIL = 8'h4b;
    localparam logic [7:0] GSC_ST_LOW = 8'h00;
    localparam logic [7:0] GSC_FILL_BYTE = 8'hff;

    localparam logic [3:0] GSC_MEAS_LEN = 4'h3;
    localparam logic [3:0] GSC_ST_LEN = 4'h3;
    localparam logic [3:0] GSC_ID_LEN = 4'h9;
    localparam logic [3:0] GSC_LAST_PARAM = 4'h7;
    localparam logic [1:0] GSC_CRC_POS = 2'h2;

    localparam int GSC_CLK_HZ = 20000000;
    localparam int GSC_MEAS_MS = 30;
    localparam int GSC_ST_MS = 320;
    localparam int GSC_ID_MS = 1;
    localparam int GSC_MEAS_CYC = GSC_MEAS_MS * (GSC_CLK_HZ / 1000);
    localparam int GSC_ST_CYC = GSC_ST_MS * (GSC_CLK_HZ / 1000);
    localparam int GSC_ID_CYC = GSC_ID_MS * (GSC_CLK_HZ / 1000);
    localparam int GSC_BUSY_W = 23;

    typedef enum logic [4:0] {
        GSC_L_IDLE = 5'h01,
        GSC_L_RX = 5'h02,
        GSC_L_RACK = 5'h04,
        GSC_L_TX = 5'h08,
        GSC_L_TACK = 5'h10
    } gsc_link_e;

    typedef enum logic [3:0] {
        GSC_JOB_NONE = 4'h1,
        GSC_JOB_MEAS = 4'h2,
        GSC_JOB_ST = 4'h4,
        GSC_JOB_ID = 4'h8
    } gsc_job_e;

    typedef struct packed {
        logic comp_en;
        logic [15:0] rh;
        logic [15:0] temp;
    } gsc_meas_cfg_s;

    typedef struct packed {
        logic [2:0] scl_sy;
        logic [2:0] sda_sy;
        gsc_link_e link;
        logic [7:0] sh;
        logic [3:0] bits;
        logic hdr, rd, gc, gc_rst, mack;
        logic [3:0] wr_cnt;
        logic [1:0] ppos;
        logic [15:0] cmd, pw, rh;
        logic [7:0] crc;
        gsc_meas_cfg_s cfg;
        gsc_job_e job;
        logic [GSC_BUSY_W-1:0] busy_cnt;
        logic busy, filling;
        logic [1:0] fill_pos;
        logic [3:0] fill;
        logic [7:0] fill_crc;
        logic [47:0] words;
        logic [3:0] resp_len, rd_idx, rd_lim;
        logic [7:0] tx;
        logic sda_oe, sda_o, heater, meas_start, st_start;
        logic mem_we;
        logic [3:0] mem_wa;
        logic [7:0] mem_wd;
    } gsc_state_s;

    localparam gsc_state_s GSC_STATE_RST = '{
        scl_sy: 3'h7, sda_sy: 3'h7, link: GSC_L_IDLE, job: GSC_JOB_NONE,
        crc: GSC_CRC_INIT, fill_crc: GSC_CRC_INIT, cfg: '0, default: '0};

    function automatic logic [7:0] gsc_crc8(input logic [7:0] c, input logic [7:0] d);
        logic [7:0] r;
        r = c ^ d;
        for (int i = 0; i < 8; i++) begin
            r = r[7] ? ((r << 1) ^ GSC_CRC_POLY) : (r << 1);
        end
        return r ^ GSC_CRC_XOR;
    endfunction : gsc_crc8

endpackage : gsc_pkg

// ---- hw/gsc_resp_mem.sv ----
// Small response byte memory with a registered read port.
`timescale 1ns/10ps
`default_nettype none
module gsc_resp_mem #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16,
    parameter int AW = 4
) (
    // Clock and reset.
    input wire logic clock_in,
    input wire logic sys_rst_in,
    // Write port.
    input wire logic wr_en_in,
    input wire logic [AW-1:0] wr_addr_in,
    input wire logic [WIDTH-1:0] wr_data_in,
    // Read port.
    input wire logic [AW-1:0] rd_addr_in,
    output logic [WIDTH-1:0] rd_data_out
);
    logic [WIDTH-1:0] mem [DEPTH];

    always_ff @(posedge clock_in) begin
        if (wr_en_in) begin
            mem[wr_addr_in] <= wr_data_in;
        end
    end

    always_ff @(posedge clock_in) begin
        if (sys_rst_in) begin
            rd_data_out <= '0;
        end else begin
            rd_data_out <= mem[rd_addr_in];
        end
    end
endmodule : gsc_resp_mem
`default_nettype wire

// ---- hw/gsc_i2c_port.sv ----
// Target-side I2C command port of the gas sensor.
//
// Behaviour
// - Commands are two bytes with no checksum byte after them.
// - Parameter and response data travel as two-byte words each followed by a CRC.
// - Only bus address 0x59 and the general call 0x00 are answered; header is address plus direction bit.
// - Standard-mode and fast-mode clock rates up to 400 kHz are supported.
// - Measurement starts when the last parameter byte of the measurement command is acknowledged.
// - While a job runs, every header with address 0x59 is refused; the general call 0x00 is still answered.
// - After the job, a read header is acknowledged and words go MSB first.
// - Master acknowledges each byte; a missing acknowledge stops transmission.
// - Results read once only; bytes beyond the response read as 0xFF.
// - CRC-8 over two bytes, polynomial 0x31, init 0xFF, no reflection, no XOR.
// - Command 0x260F takes six parameter bytes and returns one raw word.
// - Default humidity and temperature words keep compensation disabled.
// - Measurement answer is the unsigned 16-bit raw gas signal.
// - Command 0x280E runs the self-test and returns one word within 320 ms.
// - Command 0x3682 returns three identifier words, nine bytes, within 1 ms.
// - Command 0x3615 turns the heater off and returns to idle.
// - Self-test word starts with 0xD4 on pass and 0x4B on failure.
// - General-call reset 0x00 0x06 restarts the device into idle.
`timescale 1ns/10ps
`default_nettype none
module gsc_i2c_port
    import gsc_pkg::*;
#(
    parameter int unsigned MEAS_CYC = GSC_MEAS_CYC,
    parameter int unsigned ST_CYC = GSC_ST_CYC,
    parameter int unsigned ID_CYC = GSC_ID_CYC
) (
    // Clock and reset.
    input wire logic clock_in,
    input wire logic sys_rst_in,
    // I2C pins; the device never stretches the clock.
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe_out,
    // Sensing core.
    input wire logic [15:0] raw_gas_signal_in,
    input wire logic self_test_pass_in,
    input wire logic [47:0] unique_id_in,
    output logic meas_start_out,
    output logic self_test_start_out,
    output logic heater_on_out,
    output logic busy_out,
    output gsc_meas_cfg_s meas_cfg_out
);
    localparam logic [GSC_BUSY_W-1:0] MEAS_LD = GSC_BUSY_W'(MEAS_CYC);
    localparam logic [GSC_BUSY_W-1:0] ST_LD = GSC_BUSY_W'(ST_CYC);
    localparam logic [GSC_BUSY_W-1:0] ID_LD = GSC_BUSY_W'(ID_CYC);

    gsc_state_s s_reg;
    gsc_state_s s_next;
    logic [7:0] mem_rd;
    logic scl_rise, scl_fall, bus_start, bus_stop;

    // Edges come from the second and third flops; at 20 MHz a 400 kHz bit lasts 50 cycles.
    assign scl_rise = s_reg.scl_sy[1] & ~s_reg.scl_sy[2];
    assign scl_fall = ~s_reg.scl_sy[1] & s_reg.scl_sy[2];
    assign bus_start = s_reg.scl_sy[1] & s_reg.scl_sy[2] & ~s_reg.sda_sy[1] & s_reg.sda_sy[2];
    assign bus_stop = s_reg.scl_sy[1] & s_reg.scl_sy[2] & s_reg.sda_sy[1] & ~s_reg.sda_sy[2];

    gsc_resp_mem #(.WIDTH(8), .DEPTH(16), .AW(4)) u_mem (
        .clock_in(clock_in),
        .sys_rst_in(sys_rst_in),
        .wr_en_in(s_reg.mem_we),
        .wr_addr_in(s_reg.mem_wa),
        .wr_data_in(s_reg.mem_wd),
        .rd_addr_in(s_reg.rd_idx),
        .rd_data_out(mem_rd)
    );

    always_comb begin
        logic [3:0] len;
        logic [15:0] full_cmd;
        len = GSC_MEAS_LEN;
        full_cmd = {s_reg.cmd[15:8], s_reg.sh};
        s_next = s_reg;
        s_next.meas_start = 1'b0;
        s_next.st_start = 1'b0;
        s_next.mem_we = 1'b0;
        s_next.scl_sy = {s_reg.scl_sy[1:0], scl_in};
        s_next.sda_sy = {s_reg.sda_sy[1:0], sda_in};

        unique case (s_reg.job)
            GSC_JOB_ST: len = GSC_ST_LEN;
            GSC_JOB_ID: len = GSC_ID_LEN;
            GSC_JOB_MEAS, GSC_JOB_NONE: len = GSC_MEAS_LEN;
        endcase

        // A finished job is laid out in memory as words with their checksums.
        if (s_reg.busy_cnt > GSC_BUSY_W'(1)) begin
            s_next.busy_cnt = s_reg.busy_cnt - GSC_BUSY_W'(1);
        end else if (s_reg.busy_cnt == GSC_BUSY_W'(1)) begin
            s_next.busy_cnt = '0;
            s_next.filling = 1'b1;
            s_next.fill = '0;
            s_next.fill_pos = '0;
            s_next.fill_crc = GSC_CRC_INIT;
            unique case (s_reg.job)
                GSC_JOB_MEAS: s_next.words = {raw_gas_signal_in, 32'h0000_0000};
                GSC_JOB_ST: s_next.words = {self_test_pass_in ? GSC_ST_PASS : GSC_ST_FAIL,
                                            GSC_ST_LOW, 32'h0000_0000};
                GSC_JOB_ID: s_next.words = unique_id_in;
                GSC_JOB_NONE: s_next.words = '0;
            endcase
        end
        if (s_reg.filling) begin
            s_next.mem_we = 1'b1;
            s_next.mem_wa = s_reg.fill;
            s_next.fill = s_reg.fill + 4'h1;
            if (s_reg.fill_pos == GSC_CRC_POS) begin
                s_next.mem_wd = s_reg.fill_crc;
                s_next.fill_crc = GSC_CRC_INIT;
                s_next.fill_pos = '0;
            end else begin
                s_next.mem_wd = s_reg.words[47:40];
                s_next.fill_crc = gsc_crc8(s_reg.fill_crc, s_reg.words[47:40]);
                s_next.words = s_reg.words << 8;
                s_next.fill_pos = s_reg.fill_pos + 2'h1;
            end
            if (s_reg.fill == len - 4'h1) begin
                s_next.filling = 1'b0;
                s_next.resp_len = len;
                // Headers stay refused until the last byte's write is issued, one cycle before it sits in memory.
                s_next.busy = 1'b0;
            end
        end

        unique case (s_reg.link)
            GSC_L_IDLE: begin
            end
            GSC_L_RX: begin
                if (scl_rise) begin
                    s_next.sh = {s_reg.sh[6:0], s_reg.sda_sy[1]};
                    s_next.bits = s_reg.bits + 4'h1;
                end else if (scl_fall && s_reg.bits == 4'h8) begin
                    s_next.link = GSC_L_RACK;
                    s_next.sda_oe = 1'b1;
                    s_next.hdr = 1'b0;
                    if (s_reg.hdr) begin
                        if (s_reg.sh[7:1] == GSC_ADDR && !s_reg.busy) begin
                            s_next.rd = s_reg.sh[0];
                            if (s_reg.sh[0]) begin
                                // The answer is handed out once and then forgotten.
                                s_next.rd_lim = s_reg.resp_len;
                                s_next.resp_len = '0;
                                s_next.rd_idx = '0;
                            end
                        end else if (s_reg.sh == GSC_GC_HDR) begin
                            s_next.gc = 1'b1;
                        end else begin
                            s_next.link = GSC_L_IDLE;
                            s_next.sda_oe = 1'b0;
                        end
                    end else if (s_reg.gc) begin
                        s_next.gc_rst = (s_reg.sh == GSC_GC_RESET);
                        s_next.sda_oe = (s_reg.sh == GSC_GC_RESET);
                    end else begin
                        s_next.wr_cnt = s_reg.wr_cnt + 4'h1;
                        if (s_reg.wr_cnt == 4'h0) begin
                            s_next.cmd[15:8] = s_reg.sh;
                        end else if (s_reg.wr_cnt == 4'h1) begin
                            s_next.cmd = full_cmd;
                            s_next.ppos = '0;
                            s_next.resp_len = '0;
                            if (full_cmd == GSC_CMD_SELF_TEST) begin
                                s_next.job = GSC_JOB_ST;
                                s_next.busy_cnt = ST_LD;
                                s_next.busy = 1'b1;
                                s_next.st_start = 1'b1;
                            end else if (full_cmd == GSC_CMD_READ_ID) begin
                                s_next.job = GSC_JOB_ID;
                                s_next.busy_cnt = ID_LD;
                                s_next.busy = 1'b1;
                            end else if (full_cmd == GSC_CMD_HEATER_OFF) begin
                                s_next.job = GSC_JOB_NONE;
                                s_next.heater = 1'b0;
                            end else if (full_cmd != GSC_CMD_MEASURE) begin
                                s_next.link = GSC_L_IDLE;
                                s_next.sda_oe = 1'b0;
                            end
                        end else if (s_reg.cmd == GSC_CMD_MEASURE &&
                                     s_reg.wr_cnt <= GSC_LAST_PARAM) begin
                            s_next.ppos = s_reg.ppos + 2'h1;
                            if (s_reg.ppos == 2'h0) begin
                                s_next.pw[15:8] = s_reg.sh;
                                s_next.crc = gsc_crc8(GSC_CRC_INIT, s_reg.sh);
                            end else if (s_reg.ppos == 2'h1) begin
                                s_next.pw[7:0] = s_reg.sh;
                                s_next.crc = gsc_crc8(s_reg.crc, s_reg.sh);
                            end else if (s_reg.crc != s_reg.sh) begin
                                // A corrupted word is refused so the master sees the fault.
                                s_next.link = GSC_L_IDLE;
                                s_next.sda_oe = 1'b0;
                            end else if (s_reg.wr_cnt != GSC_LAST_PARAM) begin
                                s_next.ppos = '0;
                                s_next.rh = s_reg.pw;
                            end else begin
                                s_next.cfg.rh = s_reg.rh;
                                s_next.cfg.temp = s_reg.pw;
                                s_next.cfg.comp_en = !(s_reg.rh == GSC_RH_DEFAULT &&
                                                       s_reg.pw == GSC_TEMP_DEFAULT);
                                s_next.job = GSC_JOB_MEAS;
                                s_next.busy_cnt = MEAS_LD;
                                s_next.busy = 1'b1;
                                s_next.meas_start = 1'b1;
                                s_next.heater = 1'b1;
                            end
                        end else begin
                            s_next.link = GSC_L_IDLE;
                            s_next.sda_oe = 1'b0;
                        end
                    end
                end
            end
            GSC_L_RACK: begin
                if (scl_fall) begin
                    s_next.sda_oe = 1'b0;
                    s_next.bits = '0;
                    s_next.link = GSC_L_RX;
                    if (s_reg.rd) begin
                        s_next.link = GSC_L_TX;
                        s_next.tx = (s_reg.rd_idx < s_reg.rd_lim) ? mem_rd : GSC_FILL_BYTE;
                        s_next.sda_oe = (s_reg.rd_idx < s_reg.rd_lim) ? ~mem_rd[7] : 1'b0;
                    end
                end
            end
            GSC_L_TX: begin
                if (scl_fall) begin
                    if (s_reg.bits == 4'h7) begin
                        s_next.link = GSC_L_TACK;
                        s_next.sda_oe = 1'b0;
                        s_next.rd_idx = s_reg.rd_idx + 4'h1;
                    end else begin
                        s_next.tx = s_reg.tx << 1;
                        s_next.sda_oe = ~s_reg.tx[6];
                        s_next.bits = s_reg.bits + 4'h1;
                    end
                end
            end
            GSC_L_TACK: begin
                if (scl_rise) begin
                    s_next.mack = s_reg.sda_sy[1];
                end else if (scl_fall) begin
                    s_next.bits = '0;
                    if (s_reg.mack) begin
                        s_next.link = GSC_L_IDLE;
                    end else begin
                        s_next.link = GSC_L_TX;
                        s_next.tx = (s_reg.rd_idx < s_reg.rd_lim) ? mem_rd : GSC_FILL_BYTE;
                        s_next.sda_oe = (s_reg.rd_idx < s_reg.rd_lim) ? ~mem_rd[7] : 1'b0;
                    end
                end
            end
        endcase

        if (bus_stop) begin
            s_next.link = GSC_L_IDLE;
            s_next.sda_oe = 1'b0;
        end
        if (bus_start) begin
            s_next.link = GSC_L_RX;
            s_next.hdr = 1'b1;
            s_next.rd = 1'b0;
            s_next.gc = 1'b0;
            s_next.bits = '0;
            s_next.wr_cnt = '0;
            s_next.sda_oe = 1'b0;
        end
        // The reset takes effect on the falling clock edge that ends the acknowledge, releasing it in the same cycle.
        if (s_reg.gc_rst && s_reg.link == GSC_L_RACK && scl_fall) begin
            s_next = GSC_STATE_RST;
            s_next.scl_sy = {s_reg.scl_sy[1:0], scl_in};
            s_next.sda_sy = {s_reg.sda_sy[1:0], sda_in};
        end
    end

    always_ff @(posedge clock_in) begin
        if (sys_rst_in) begin
            s_reg <= GSC_STATE_RST;
        end else begin
            s_reg <= s_next;
        end
    end

    assign sda_out = s_reg.sda_o;
    assign sda_oe_out = s_reg.sda_oe;
    assign meas_start_out = s_reg.meas_start;
    assign self_test_start_out = s_reg.st_start;
    assign heater_on_out = s_reg.heater;
    assign busy_out = s_reg.busy;
    assign meas_cfg_out = s_reg.cfg;

    // The busy flag follows the count and the fill, and changes in the same cycle as them.
    logic busy_ok;
    assign busy_ok = s_reg.busy || (s_reg.busy_cnt == '0 && !s_reg.filling);

    default clocking dc @(posedge clock_in); endclocking
    default disable iff (sys_rst_in);

    busy_nack_a: assert property ((s_reg.link == GSC_L_RX && s_reg.hdr && scl_fall &&
        s_reg.bits == 4'h8 && s_reg.sh[7:1] == GSC_ADDR && s_reg.busy && !bus_start)
        |=> !sda_oe_out && s_reg.link == GSC_L_IDLE)
        else $error("header acknowledged while busy");
    addr_ack_a: assert property ((s_reg.link == GSC_L_RX && s_reg.hdr && scl_fall &&
        s_reg.bits == 4'h8 && s_reg.sh[7:1] == GSC_ADDR && !s_reg.busy && !bus_start && !bus_stop)
        |=> sda_oe_out && s_reg.link == GSC_L_RACK)
        else $error("own address not acknowledged");
    meas_launch_a: assert property (meas_start_out |-> sda_oe_out && heater_on_out &&
        s_reg.busy_cnt == MEAS_LD && s_reg.job == GSC_JOB_MEAS)
        else $error("measurement launch not tied to acknowledge");
    comp_default_a: assert property (meas_start_out |-> meas_cfg_out.comp_en ==
        !(meas_cfg_out.rh == GSC_RH_DEFAULT && meas_cfg_out.temp == GSC_TEMP_DEFAULT))
        else $error("compensation flag wrong");
    ff_beyond_a: assert property ((s_reg.link == GSC_L_TACK && scl_fall && !s_reg.mack &&
        !bus_start && !bus_stop && s_reg.rd_idx >= s_reg.rd_lim) |=> s_reg.tx == GSC_FILL_BYTE)
        else $error("byte beyond response not all ones");
    nack_stop_a: assert property ((s_reg.link == GSC_L_TACK && scl_fall && s_reg.mack &&
        !bus_start) |=> s_reg.link == GSC_L_IDLE ##1 !sda_oe_out)
        else $error("transmission continued after missing acknowledge");
    msb_first_a: assert property ((s_reg.link == GSC_L_TX && scl_fall && s_reg.bits != 4'h7 &&
        !bus_start && !bus_stop) |=> sda_oe_out == ~$past(s_reg.tx[6]))
        else $error("data bit order wrong");
    id_len_a: assert property ($fell(s_reg.filling) && s_reg.job == GSC_JOB_ID |->
        s_reg.resp_len == GSC_ID_LEN)
        else $error("identifier response length wrong");
    busy_flag_a: assert property (busy_ok)
        else $error("busy flag low while a job runs");
endmodule : gsc_i2c_port
`default_nettype wire

// ---- sim/gsc_master_model.sv ----
// Behavioural I2C bus master that drives the command port.
`timescale 1ns/10ps
`default_nettype none
module gsc_master_model (
    // Clock and wired bus level.
    input wire logic clock_in,
    input wire logic sda_in,
    // Master pin levels; the bus clock stands still between frames.
    output logic scl_out,
    output logic sda_out
);
    initial begin
        scl_out = 1'b1;
        sda_out = 1'b1;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge clock_in);
    endtask : tick
    // Eight system clocks per bit make a 400 ns bus clock.
    task automatic bit_x(input logic b, output logic s);
        scl_out <= 1'b0;
        tick(1);
        sda_out <= b;
        tick(4);
        scl_out <= 1'b1;
        tick(3);
        s = sda_in;
    endtask : bit_x
    // A start when b is high, a stop when it is low.
    task automatic cond(input logic b);
        scl_out <= 1'b0;
        tick(1);
        sda_out <= b;
        tick(4);
        scl_out <= 1'b1;
        tick(4);
        sda_out <= !b;
        tick(4);
    endtask : cond
    task automatic wbyte(input logic [7:0] b, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) bit_x(b[i], s);
        bit_x(1'b1, s);
        ack = !s;
    endtask : wbyte
    task automatic rbyte(input logic ack, output logic [7:0] b);
        logic s;
        for (int i = 7; i >= 0; i--) bit_x(1'b1, b[i]);
        bit_x(!ack, s);
    endtask : rbyte
endmodule : gsc_master_model
`default_nettype wire

// ---- sim/gsc_i2c_port_tb_top.sv ----
// Self-checking bench for the gas sensor command port.
`timescale 1ns/10ps
`default_nettype none
module gsc_i2c_port_tb_top;
    import gsc_pkg::*;
    typedef struct packed {
        logic [15:0] c, rh, t, word;
        logic pass, comp, heat;
    } gsc_row_s;
    gsc_row_s rows[5] = '{
        '{16'h260f, 16'h8000, 16'h6666, 16'h1234, 1'b0, 1'b0, 1'b1},
        '{16'h280e, 16'h0000, 16'h0000, 16'hd400, 1'b1, 1'b0, 1'b1},
        '{16'h3615, 16'h0000, 16'h0000, 16'h0000, 1'b0, 1'b0, 1'b0},
        '{16'h260f, 16'h0000, 16'hffff, 16'hbeef, 1'b0, 1'b1, 1'b1},
        '{16'h280e, 16'h0000, 16'h0000, 16'h4b00, 1'b0, 1'b0, 1'b1}};
    logic clock_in = 1'b0;
    logic sys_rst_in = 1'b1;
    logic pass = 1'b0;
    logic [15:0] raw = 16'h0000;
    logic [47:0] uid = 48'h0000_0000_0000;
    int ms_cnt, sts_cnt;
    logic scl, m_sda, sda_o, sda_oe, ms, sts, heat, busy, ack;
    logic [7:0] rx[9];
    int polls, err_count = 0, tests_run = 0;
    gsc_meas_cfg_s cfg;
    // Open drain: the pull-up wins unless someone pulls low.
    wire logic sda = m_sda & (sda_o | !sda_oe);
    always #25 clock_in = !clock_in;
    // Launch pulses last one cycle, so they are counted as they pass.
    always @(posedge clock_in) begin
        if (sys_rst_in) begin
            ms_cnt <= 0;
            sts_cnt <= 0;
        end else begin
            if (ms) ms_cnt <= ms_cnt + 1;
            if (sts) sts_cnt <= sts_cnt + 1;
        end
    end
    gsc_i2c_port #(.MEAS_CYC(200), .ST_CYC(300), .ID_CYC(100)) gsc_i2c_port_i (
        .clock_in(clock_in), .sys_rst_in(sys_rst_in), .scl_in(scl), .sda_in(sda),
        .sda_out(sda_o), .sda_oe_out(sda_oe), .raw_gas_signal_in(raw),
        .self_test_pass_in(pass), .unique_id_in(uid), .meas_start_out(ms),
        .self_test_start_out(sts), .heater_on_out(heat), .busy_out(busy), .meas_cfg_out(cfg));
    gsc_master_model gsc_master_model_i (
        .clock_in(clock_in), .sda_in(sda), .scl_out(scl), .sda_out(m_sda));
    function automatic logic [7:0] crc(input logic [15:0] w);
        logic [7:0] c;
        c = 8'hff;
        for (int i = 15; i >= 0; i--) c = {c[6:0], 1'b0} ^ ((c[7] ^ w[i]) ? 8'h31 : 8'h00);
        return c;
    endfunction : crc
    task automatic chk(input string n, input logic [47:0] seen, input logic [47:0] exp);
        tests_run++;
        if (seen !== exp) begin
            err_count++;
            $display("[ERR] %s expected %h seen %h", n, exp, seen);
        end
    endtask : chk
    // Header, command word, then np parameter bytes; stops at the first refusal.
    task automatic send(input logic [7:0] h, input logic [15:0] c, input logic [47:0] p,
                        input int np);
        gsc_master_model_i.cond(1'b1);
        gsc_master_model_i.wbyte(h, ack);
        for (int i = 0; i < 2 + np; i++) begin
            if (ack) gsc_master_model_i.wbyte(i < 2 ? c[15-8*i -: 8] : p[63-8*i -: 8], ack);
        end
        gsc_master_model_i.cond(1'b0);
    endtask : send
    // Polls the read header until it is taken, then reads n bytes.
    task automatic fetch(input int n);
        logic a;
        a = 1'b0;
        polls = 0;
        while (!a && polls < 40) begin
            gsc_master_model_i.cond(1'b1);
            gsc_master_model_i.wbyte(8'hb3, a);
            polls++;
        end
        for (int i = 0; i < n; i++) gsc_master_model_i.rbyte(i < n - 1, rx[i]);
        gsc_master_model_i.cond(1'b0);
    endtask : fetch
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : end_of_test
    initial begin
        repeat (100000) @(posedge clock_in);
        err_count++;
        end_of_test();
    end
    initial begin
        repeat (8) @(posedge clock_in);
        sys_rst_in <= 1'b0;
        repeat (4) @(posedge clock_in);
        chk("reset", {sda_oe, busy, heat, ms, sts}, 5'h00);
        foreach (rows[i]) begin
            raw <= rows[i].word;
            pass <= rows[i].pass;
            send(8'hb2, rows[i].c, {rows[i].rh, crc(rows[i].rh), rows[i].t, crc(rows[i].t)},
                 rows[i].c == 16'h260f ? 6 : 0);
            chk("cmd ack", ack, 1'b1);
            chk("heater", heat, rows[i].heat);
            if (rows[i].c == 16'h260f) chk("cfg", cfg, {rows[i].comp, rows[i].rh, rows[i].t});
            if (rows[i].c != 16'h3615) begin
                fetch(4);
                chk("busy refusal", polls > 1, 1'b1);
                chk("word", {rx[0], rx[1]}, rows[i].word);
                chk("crc", rx[2], crc(rows[i].word));
                chk("beyond end", rx[3], 8'hff);
            end
            $display("row %0d finished", i);
        end
        fetch(2);
        chk("second read", {rx[0], rx[1]}, 16'hffff);
        send(8'hb4, 16'h260f, 48'h0, -2);
        chk("foreign address", ack, 1'b0);
        send(8'hb2, 16'h260f, 48'h8000_0066_6693, 6);
        chk("bad crc", {ack, busy}, 2'h0);
        chk("launch pulses", {ms_cnt[7:0], sts_cnt[7:0]}, 16'h0202);
        $display("refusals finished");
        uid <= 48'h0123_4567_89ab;
        send(8'hb2, 16'h3682, 48'h0, 0);
        fetch(9);
        for (int j = 0; j < 3; j++) begin
            chk("id word", {rx[3*j], rx[3*j+1]}, uid[47-16*j -: 16]);
            chk("id crc", rx[3*j+2], crc(uid[47-16*j -: 16]));
        end
        $display("identifier finished");
        send(8'h00, 16'h0600, 48'h0, -1);
        chk("soft reset", {ack, heat, busy}, 3'h4);
        $display("soft reset finished");
        end_of_test();
    end
endmodule : gsc_i2c_port_tb_top
`default_nettype wire
